// File: bench/ardc_host_model.sv
`timescale 1ns/10ps
module ardc_host_model (
   input  wire logic sys_clk,
   input  wire logic serial_out_lane0,
   output logic      chip_select_n,
   output logic      serial_clock,
   output logic      serial_in_pin,
   output logic      conversion_trigger
);
   // ------------------------------------------------------------
   // host side of the serial port, clock idles low
   // ------------------------------------------------------------
   initial begin
      chip_select_n      = 1'b1;
      serial_clock       = 1'b0;
      serial_in_pin      = 1'b0;
      conversion_trigger = 1'b0;
   end
   task automatic half();
      repeat (6) @(posedge sys_clk);
   endtask : half
   task automatic convert();
      @(posedge sys_clk);
      conversion_trigger <= 1'b1;
      repeat (4) @(posedge sys_clk);
      conversion_trigger <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask : convert
   // mode zero frame of n capture edges, never under 20 per device
   task automatic frame(input int n, input logic [39:0] din, output logic [39:0] dout);
      dout = '0;
      @(posedge sys_clk);
      chip_select_n <= 1'b0;
      serial_in_pin <= din[n-1];
      for (int i = 0; i < n; i++) begin
         half();
         serial_clock <= 1'b1;
         dout = {dout[38:0], serial_out_lane0};
         half();
         serial_clock <= 1'b0;
         if (i < n - 1) serial_in_pin <= din[n-2-i];
      end
      half();
      chip_select_n <= 1'b1;
      serial_in_pin <= ~serial_in_pin;
      repeat (12) @(posedge sys_clk);
   endtask : frame
endmodule : ardc_host_model

// File: bench/ardc_readout_props.sv
`timescale 1ns/10ps
module ardc_readout_props
   import ardc_pkg::*;
(
   input wire logic                 sys_clk,
   input wire logic                 nrst,
   input wire logic                 chip_select_n,
   input wire logic                 serial_clock,
   input wire logic                 serial_in_pin,
   input wire logic                 conversion_trigger,
   input wire logic [WORD_BITS-1:0] sample_word,
   input wire logic [7:0]           output_protocol_ctrl,
   input wire logic [7:0]           input_protocol_ctrl,
   input wire logic                 cmd_ready,
   input wire logic                 ready_strobe_out,
   input wire logic                 serial_out_lane0,
   input wire logic [2:0]           serial_out_hi,
   input wire logic                 sample_strobe,
   input wire logic                 cmd_valid,
   input wire logic [WORD_BITS-1:0] cmd_word,
   input wire logic                 source_sync_mode
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   // ------------------------------------------------------------
   // port properties
   // ------------------------------------------------------------
   property p_idle_strobe;
      chip_select_n [*8] |-> !ready_strobe_out;
   endproperty
   a_idle_strobe : assert property (p_idle_strobe) else $error("strobe active between frames");
   property p_legacy_strobe;
      (output_protocol_ctrl[1:0] != MODE_SRC) [*3] |-> !ready_strobe_out;
   endproperty
   a_legacy_strobe : assert property (p_legacy_strobe) else $error("strobe active in legacy mode");
   property p_mode_flag;
      $stable(output_protocol_ctrl[1:0]) |-> source_sync_mode == (output_protocol_ctrl[1:0] == MODE_SRC);
   endproperty
   a_mode_flag : assert property (p_mode_flag) else $error("mode flag wrong");
   property p_single_hi;
      (chip_select_n && !output_protocol_ctrl[WIDTH_HI]) [*4] |-> serial_out_hi == 3'h0;
   endproperty
   a_single_hi : assert property (p_single_hi) else $error("upper lanes busy in single width");
   property p_dual_hi;
      (chip_select_n && output_protocol_ctrl[3:2] != WIDTH_QUAD) [*4] |-> serial_out_hi[2:1] == 2'h0;
   endproperty
   a_dual_hi : assert property (p_dual_hi) else $error("lanes two and three busy");
   property p_sample_pulse;
      sample_strobe |=> !sample_strobe;
   endproperty
   a_sample_pulse : assert property (p_sample_pulse) else $error("sample strobe too long");
   property p_sample_cause;
      $rose(conversion_trigger) |-> ##[1:5] sample_strobe;
   endproperty
   a_sample_cause : assert property (p_sample_cause) else $error("trigger not sampled");
   property p_cmd_hold;
      cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_word);
   endproperty
   a_cmd_hold : assert property (p_cmd_hold) else $error("command word dropped");
   property p_cmd_issue;
      $rose(chip_select_n) && output_protocol_ctrl == CTRL_RESET && !cmd_valid |-> ##[1:8] cmd_valid;
   endproperty
   a_cmd_issue : assert property (p_cmd_issue) else $error("no command after frame");
   c_src_clock : cover property (source_sync_mode && $rose(ready_strobe_out));
   c_cmd_taken : cover property (cmd_valid && cmd_ready);
   c_sample : cover property (sample_strobe);
endmodule : ardc_readout_props

bind ardc_readout ardc_readout_props u_props (.sys_clk, .nrst, .chip_select_n, .serial_clock, .serial_in_pin,
   .conversion_trigger, .sample_word, .output_protocol_ctrl, .input_protocol_ctrl, .cmd_ready, .ready_strobe_out,
   .serial_out_lane0, .serial_out_hi, .sample_strobe, .cmd_valid, .cmd_word, .source_sync_mode);

// File: bench/ardc_readout_tb_top.sv
`timescale 1ns/10ps
module ardc_readout_tb_top
   import ardc_pkg::*;
();
   logic                 sys_clk, nrst, chip_select_n, serial_clock, serial_in_pin, conversion_trigger;
   logic [WORD_BITS-1:0] sample_word, cmd_word;
   logic [7:0]           output_protocol_ctrl, input_protocol_ctrl;
   logic                 cmd_ready, ready_strobe_out, serial_out_lane0, sample_strobe, cmd_valid, source_sync_mode;
   logic [2:0]           serial_out_hi;
   logic [39:0]          got;
   int                   errors, checked;

   ardc_readout u_dut (.sys_clk, .nrst, .chip_select_n, .serial_clock, .serial_in_pin, .conversion_trigger,
      .sample_word, .output_protocol_ctrl, .input_protocol_ctrl, .cmd_ready, .ready_strobe_out, .serial_out_lane0,
      .serial_out_hi, .sample_strobe, .cmd_valid, .cmd_word, .source_sync_mode);
   ardc_host_model u_host (.sys_clk, .serial_out_lane0, .chip_select_n, .serial_clock, .serial_in_pin,
      .conversion_trigger);

   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [39:0] exp, input logic [39:0] seen);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic pop();
      @(posedge sys_clk);
      cmd_ready <= 1'b1;
      @(posedge sys_clk);
      cmd_ready <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask : pop
   task automatic src_check(input logic [7:0] code, input logic [19:0] w);
      int          lanes;
      int          n;
      logic [19:0] acc;
      logic [39:0] dummy;
      logic        prev;
      logic [3:0]  vec;
      lanes = code[WIDTH_HI] ? (code[WIDTH_LO] ? 4 : 2) : 1;
      n = 0;
      acc = '0;
      prev = 1'b0;
      output_protocol_ctrl <= code;
      sample_word <= w;
      u_host.convert();
      fork
         u_host.frame(24, 40'h00_0000_0000, dummy);
         repeat (330) begin
            @(posedge sys_clk);
            #1;
            vec = {serial_out_lane0, serial_out_hi[0], serial_out_hi[1], serial_out_hi[2]};
            if (n < 20 && ready_strobe_out !== prev && (ready_strobe_out === 1'b1 || code[RATE_BIT])) begin
               for (int j = 0; j < lanes; j++) acc = {acc[18:0], vec[3-j]};
               n += lanes;
            end
            prev = ready_strobe_out;
         end
      join
      check("source sync word", {20'h0_0000, w}, {20'h0_0000, acc});
   endtask : src_check
   task automatic results();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      sample_word = '0;
      output_protocol_ctrl = 8'h00;
      input_protocol_ctrl = 8'h00;
      cmd_ready = 1'b0;
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check("reset outputs", 40'h00_0000_0000, {ready_strobe_out, serial_out_lane0, serial_out_hi, sample_strobe,
         cmd_valid, source_sync_mode, cmd_word});
      sample_word <= 20'h9_3C5A;
      u_host.convert();
      u_host.frame(20, 40'h00_0006_A1F3, got);
      check("chain word out", 40'h00_0009_3C5A, got);
      sample_word <= 20'h2_B0D7;
      u_host.convert();
      u_host.frame(40, 40'h51_E88C_4D21, got);
      check("chain pass through", 40'h2B_0D75_1E88, got);
      u_host.frame(20, 40'h00_0007_7E19, got);
      check("first command", 40'h00_0016_A1F3, {19'h0, cmd_valid, cmd_word});
      pop();
      check("second command", 40'h00_001C_4D21, {19'h0, cmd_valid, cmd_word});
      pop();
      check("third command dropped", 40'h00_0000_0000, {39'h0, cmd_valid});
      cmd_ready <= 1'b1;
      output_protocol_ctrl <= 8'h08;
      u_host.frame(40, 40'hA5_A5A0_0000, got);
      checked++;
      if (got[19:0] === 20'hA_5A5A) begin
         errors++;
         $display("mismatch chain with control set expected other than %h seen %h", 20'hA_5A5A, got[19:0]);
      end
      for (int k = 0; k < 32; k++) if (k[1:0] != 2'h1) src_check({k[4:3], 1'b0, k[2], k[1:0], MODE_SRC},
         20'h3_96C1 + 20'(k));
      results();
   end
   initial begin
      repeat (40000) @(posedge sys_clk);
      errors++;
      results();
   end
endmodule : ardc_readout_tb_top

// File: logic/ardc_pkg.sv
package ardc_pkg;

   // ------------------------------------------------------------
   // word and control layout
   // ------------------------------------------------------------
   localparam int          WORD_BITS      = 20;
   localparam int          CNT_BITS       = 5;
   localparam logic [7:0]  CTRL_RESET     = 8'h00;
   localparam logic [7:0]  IN_CTRL_RESET  = 8'h00;
   localparam logic [3:0]  SYNC_IDLE      = 4'h8;
   localparam int          CLK_SEL_HI     = 7;
   localparam int          CLK_SEL_LO     = 6;
   localparam int          RATE_BIT       = 4;
   localparam int          WIDTH_HI       = 3;
   localparam int          WIDTH_LO       = 2;
   localparam int          MODE_HI        = 1;
   localparam int          MODE_LO        = 0;
   localparam logic [1:0]  MODE_LEGACY    = 2'h0;
   localparam logic [1:0]  MODE_SRC       = 2'h3;
   localparam logic [1:0]  WIDTH_DUAL     = 2'h2;
   localparam logic [1:0]  WIDTH_QUAD     = 2'h3;
   localparam logic [1:0]  CLK_ECHO       = 2'h0;
   localparam logic [1:0]  CLK_INT        = 2'h1;
   localparam logic [1:0]  CLK_INT_DIV2   = 2'h2;
   localparam logic [1:0]  CLK_INT_DIV4   = 2'h3;
   localparam logic [2:0]  LANES_ONE      = 3'h1;
   localparam logic [2:0]  LANES_TWO      = 3'h2;
   localparam logic [2:0]  LANES_FOUR     = 3'h4;
   localparam logic [1:0]  DIV_ONE_LAST   = 2'h0;
   localparam logic [1:0]  DIV_TWO_LAST   = 2'h1;
   localparam logic [1:0]  DIV_FOUR_LAST  = 2'h3;

   typedef enum logic [1:0] {
      ARDC_IDLE,
      ARDC_CHAIN,
      ARDC_SRC
   } ardc_state_type;

   typedef struct packed {
      logic [1:0] clk_sel;
      logic       ddr;
      logic [1:0] width;
      logic [1:0] mode;
   } ardc_cfg_type;

   typedef struct packed {
      logic [WORD_BITS-1:0] word;
   } ardc_word_type;

   function automatic ardc_cfg_type ardc_decode(input logic [7:0] ctrl);
      ardc_cfg_type c;
      c.clk_sel = ctrl[CLK_SEL_HI:CLK_SEL_LO];
      c.ddr     = ctrl[RATE_BIT];
      c.width   = ctrl[WIDTH_HI:WIDTH_LO];
      c.mode    = ctrl[MODE_HI:MODE_LO];
      return c;
   endfunction : ardc_decode

endpackage : ardc_pkg

// File: logic/ardc_readout.sv
`timescale 1ns/10ps
// What this block does
// - nonzero output control: no chaining through on long frames
// - source-synchronous: ready strobe carries output clock synchronous with data
// - output clock from host clock or internal clock, optionally divided by two or four
// - dual width: two bits per launch edge on lanes zero and one
// - quad width: four bits per launch edge on lanes zero to three
// - defaults are single data rate and one output lane
// - sdr: strobe rises, data launched on each rising edge
// - ddr: strobe toggles, data on every edge, first on a rising edge
// - all clock source, lane and rate combinations selectable by control codes
// - chain mode merges output and input shift registers into one 20-bit register
// - conversion trigger rising samples input; frame starts at chip select falling
// - chain launch edge shifts register msb onto lane zero
// - chain capture edge shifts serial input into register lsb
// - chip select rising in chain mode: register contents taken as command, dropped when both buffer entries are full
// - clock select: 00 echo, 01 internal, 10 halved, 11 quartered
// - data rate ignored in legacy mode, effective only in source-synchronous
// - reset returns to legacy mode-zero single-lane protocol
module ardc_readout
   import ardc_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 nrst,
   input  wire logic                 chip_select_n,
   input  wire logic                 serial_clock,
   input  wire logic                 serial_in_pin,
   input  wire logic                 conversion_trigger,
   input  wire logic [WORD_BITS-1:0] sample_word,
   input  wire logic [7:0]           output_protocol_ctrl,
   input  wire logic [7:0]           input_protocol_ctrl,
   input  wire logic                 cmd_ready,
   output logic                      ready_strobe_out,
   output logic                      serial_out_lane0,
   output logic [2:0]                serial_out_hi,
   output logic                      sample_strobe,
   output logic                      cmd_valid,
   output logic [WORD_BITS-1:0]      cmd_word,
   output logic                      source_sync_mode
);

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [3:0] sync_a;
   logic [3:0] sync_b;
   logic       cs_prev;
   logic       sck_prev;
   logic       cvt_prev;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         // idle pin levels: select high, clock, data and trigger low
         sync_a <= SYNC_IDLE;
         sync_b <= SYNC_IDLE;
      end else begin
         sync_a <= {chip_select_n, serial_clock, serial_in_pin, conversion_trigger};
         sync_b <= sync_a;
      end
   end

   logic cs_n_s;
   logic sck_s;
   logic sdi_s;
   logic cvt_s;
   assign cs_n_s = sync_b[3];
   assign sck_s  = sync_b[2];
   assign sdi_s  = sync_b[1];
   assign cvt_s  = sync_b[0];

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cs_prev  <= 1'b1;
         sck_prev <= 1'b0;
         cvt_prev <= 1'b0;
      end else begin
         cs_prev  <= cs_n_s;
         sck_prev <= sck_s;
         cvt_prev <= cvt_s;
      end
   end

   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic cvt_rise;
   assign cs_fall  = cs_prev & ~cs_n_s;
   assign cs_rise  = ~cs_prev & cs_n_s;
   assign sck_rise = ~sck_prev & sck_s;
   assign sck_fall = sck_prev & ~sck_s;
   assign cvt_rise = ~cvt_prev & cvt_s;

   // ------------------------------------------------------------
   // configuration
   // ------------------------------------------------------------
   ardc_cfg_type cfg;
   logic         is_src;
   logic         ddr_eff;
   logic [2:0]   lanes;
   logic         cpha;
   logic         cpol;

   assign cfg     = ardc_decode(output_protocol_ctrl);
   assign is_src  = (cfg.mode == MODE_SRC);
   assign ddr_eff = is_src & cfg.ddr;
   assign cpol    = input_protocol_ctrl[1];
   assign cpha    = input_protocol_ctrl[0];

   always_comb begin
      if (cfg.width == WIDTH_QUAD) begin
         lanes = LANES_FOUR;
      end else if (cfg.width == WIDTH_DUAL) begin
         lanes = LANES_TWO;
      end else begin
         lanes = LANES_ONE;
      end
   end

   // legacy launch/capture edges follow polarity and phase
   logic cap_edge;
   logic lau_edge;
   assign cap_edge = (cpol ^ cpha) ? sck_fall : sck_rise;
   assign lau_edge = (cpol ^ cpha) ? sck_rise : sck_fall;

   // ------------------------------------------------------------
   // conversion sample
   // ------------------------------------------------------------
   logic [WORD_BITS-1:0] held_word;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         held_word     <= '0;
         sample_strobe <= 1'b0;
      end else begin
         sample_strobe <= cvt_rise;
         if (cvt_rise) begin
            held_word <= sample_word;
         end
      end
   end

   // ------------------------------------------------------------
   // frame engine
   // ------------------------------------------------------------
   ardc_state_type       state;
   logic [WORD_BITS-1:0] shift_chain;
   logic [CNT_BITS-1:0]  cap_count;
   logic [1:0]           div_cnt;
   logic [1:0]           div_last;
   logic                 src_tick;
   logic                 strobe;
   logic                 first_launched;

   always_comb begin
      case (cfg.clk_sel)
         CLK_INT:      div_last = DIV_ONE_LAST;
         CLK_INT_DIV2: div_last = DIV_TWO_LAST;
         CLK_INT_DIV4: div_last = DIV_FOUR_LAST;
         default:      div_last = DIV_ONE_LAST;
      endcase
      if (cfg.clk_sel == CLK_ECHO) begin
         src_tick = sck_rise | sck_fall;
      end else begin
         src_tick = (div_cnt == div_last);
      end
   end

   // next strobe level and whether data launches on this tick
   logic next_strobe;
   logic launch_now;
   always_comb begin
      next_strobe = ~strobe;
      launch_now  = src_tick & (ddr_eff | ~strobe);
   end

   logic [WORD_BITS-1:0] shifted;
   always_comb begin
      case (lanes)
         LANES_FOUR: shifted = {shift_chain[WORD_BITS-5:0], 4'h0};
         LANES_TWO:  shifted = {shift_chain[WORD_BITS-3:0], 2'h0};
         default:    shifted = {shift_chain[WORD_BITS-2:0], 1'b0};
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state            <= ARDC_IDLE;
         shift_chain      <= '0;
         cap_count        <= '0;
         div_cnt          <= '0;
         strobe           <= 1'b0;
         first_launched   <= 1'b0;
         serial_out_lane0 <= 1'b0;
         serial_out_hi    <= 3'h0;
         source_sync_mode <= 1'b0;
      end else begin
         source_sync_mode <= is_src;
         case (state)
            ARDC_IDLE: begin
               strobe        <= 1'b0;
               serial_out_hi <= 3'h0;
               div_cnt       <= '0;
               if (cs_fall) begin
                  shift_chain    <= held_word;
                  cap_count      <= '0;
                  first_launched <= 1'b0;
                  if (is_src) begin
                     state <= ARDC_SRC;
                  end else begin
                     state            <= ARDC_CHAIN;
                     serial_out_lane0 <= cpha ? 1'b0 : held_word[WORD_BITS-1];
                  end
               end
            end
            ARDC_CHAIN: begin
               if (cs_rise) begin
                  state <= ARDC_IDLE;
               end else begin
                  if (lau_edge) begin
                     serial_out_lane0 <= shift_chain[WORD_BITS-1];
                     serial_out_hi    <= (lanes == LANES_ONE) ? 3'h0 :
                                         {shift_chain[WORD_BITS-4], shift_chain[WORD_BITS-3],
                                          shift_chain[WORD_BITS-2]} & {lanes[2], lanes[2], 1'b1};
                  end
                  if (cap_edge) begin
                     // unified register only in legacy mode with control cleared
                     if (output_protocol_ctrl == CTRL_RESET) begin
                        shift_chain <= {shift_chain[WORD_BITS-2:0], sdi_s};
                     end else if (cap_count < CNT_BITS'(WORD_BITS)) begin
                        shift_chain <= {shift_chain[WORD_BITS-2:0], 1'b0};
                     end
                     if (cap_count != '1) begin
                        cap_count <= cap_count + 1'b1;
                     end
                  end
               end
            end
            ARDC_SRC: begin
               if (cs_rise) begin
                  state  <= ARDC_IDLE;
                  strobe <= 1'b0;
               end else begin
                  div_cnt <= (div_cnt == div_last) ? 2'h0 : div_cnt + 2'h1;
                  if (src_tick) begin
                     strobe <= next_strobe;
                  end
                  if (launch_now) begin
                     first_launched   <= 1'b1;
                     serial_out_lane0 <= shift_chain[WORD_BITS-1];
                     serial_out_hi    <= {shift_chain[WORD_BITS-4] & lanes[2],
                                          shift_chain[WORD_BITS-3] & lanes[2],
                                          shift_chain[WORD_BITS-2] & ~lanes[0]};
                     shift_chain      <= shifted;
                  end
               end
            end
            default: state <= ARDC_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ready_strobe_out <= 1'b0;
      end else begin
         // launched on the same edge as the data it clocks
         if ((state == ARDC_SRC) && !cs_rise) begin
            ready_strobe_out <= src_tick ? next_strobe : strobe;
         end else begin
            ready_strobe_out <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // command buffer, two entries
   // ------------------------------------------------------------
   ardc_word_type        buf_mem [2];
   logic                 wr_ptr;
   logic                 rd_ptr;
   logic [1:0]           buf_cnt;
   logic                 push;
   logic                 pop;

   assign push = (state == ARDC_CHAIN) & cs_rise & (buf_cnt != 2'h2);
   assign pop  = cmd_valid & cmd_ready;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wr_ptr  <= 1'b0;
         rd_ptr  <= 1'b0;
         buf_cnt <= 2'h0;
      end else begin
         if (push) begin
            buf_mem[wr_ptr].word <= shift_chain;
            wr_ptr               <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cmd_valid <= 1'b0;
         cmd_word  <= '0;
      end else begin
         cmd_valid <= (buf_cnt - {1'b0, pop}) != 2'h0 || push;
         if (pop || !cmd_valid) begin
            cmd_word <= (buf_cnt - {1'b0, pop} != 2'h0) ? buf_mem[rd_ptr ^ pop].word : shift_chain;
         end
      end
   end

endmodule : ardc_readout
